// >>> hw/bsl_pkg.sv
// Behaviour
// - bootstrap reset takes vector from boot ROM
// - first character picks baud rate; host sends first
// - received bytes stored in consecutive RAM
// - download complete then jump into RAM
// - protected mode bits writable in bootstrap mode
// - clearing ROM enable unmaps boot ROM
// - ROM enable: 0 protected normally, 1 writable bootstrap
// - mapped boot ROM overrides underlying ROM reads
// - transmitter double buffered: holding plus shifter
// - every character stored in RAM echoed back
// - line silence for timeout ends variable download
// - extra sync values pick other rates, timeouts
package bsl_pkg;
  // ==========================================================
  // clock and serial timing
  localparam int CLK_HZ     = 10_000_000;
  localparam int OVERSAMPLE = 16;
  localparam int BAUD_FAST  = 7812;
  localparam int BAUD_SLOW  = 1200;
  localparam int BAUD_F0    = 9600;
  localparam int BAUD_FD    = 5208;
  localparam int DIV_W      = 12;
  localparam logic [DIV_W-1:0] DIV_FAST =
    DIV_W'(CLK_HZ / (BAUD_FAST * OVERSAMPLE));
  localparam logic [DIV_W-1:0] DIV_SLOW =
    DIV_W'(CLK_HZ / (BAUD_SLOW * OVERSAMPLE));
  localparam logic [DIV_W-1:0] DIV_F0 =
    DIV_W'(CLK_HZ / (BAUD_F0 * OVERSAMPLE));
  localparam logic [DIV_W-1:0] DIV_FD =
    DIV_W'(CLK_HZ / (BAUD_FD * OVERSAMPLE));
  localparam logic [3:0] SMP_MID    = 4'h7;
  localparam logic [3:0] BIT_STOP   = 4'h9;
  // intercharacter timeouts in tenths of a character time
  localparam int TO_STD_TENTHS = 40;
  localparam int TO_F0_TENTHS  = 49;
  localparam int TO_FD_TENTHS  = 173;
  localparam int TICKS_PER_TENTH = OVERSAMPLE * 10 / 10;
  localparam int TO_W = 12;
  localparam logic [TO_W-1:0] TO_STD =
    TO_W'(TO_STD_TENTHS * TICKS_PER_TENTH);
  localparam logic [TO_W-1:0] TO_F0 =
    TO_W'(TO_F0_TENTHS * TICKS_PER_TENTH);
  localparam logic [TO_W-1:0] TO_FD =
    TO_W'(TO_FD_TENTHS * TICKS_PER_TENTH);
  // ==========================================================
  // sync characters
  localparam logic [7:0] SYNC_FF = 8'hFF;
  localparam logic [7:0] SYNC_F0 = 8'hF0;
  localparam logic [7:0] SYNC_FD = 8'hFD;
  // ==========================================================
  // memory map
  localparam logic [7:0]  BOOT_ROM_PAGE = 8'hBF;
  localparam logic [15:0] VEC_BOOT      = 16'hBFFE;
  localparam logic [15:0] VEC_MAIN      = 16'hFFFE;
  localparam logic [15:0] BOOT_ENTRY    = 16'hBF40;
  localparam logic [7:0]  VEC_HI_OFS    = 8'hFE;
  localparam logic [7:0]  VEC_LO_OFS    = 8'hFF;
  localparam logic [15:0] LOAD_BASE     = 16'h0000;
  // ==========================================================
  // priority/miscellaneous register
  localparam int BIT_BOOT_EN = 7;
  localparam logic [7:0] MISC_PROT_MASK = 8'hE0;
  localparam logic [7:0] MISC_RST_NORM  = 8'h00;
  localparam logic [7:0] MISC_RST_BOOT  = 8'hC0;
  // ==========================================================
  typedef enum logic [1:0] {
    BSL_R_FAST, BSL_R_SLOW, BSL_R_F0, BSL_R_FD
  } bsl_rate_t;
  typedef enum logic [1:0] {
    BSL_S_IDLE, BSL_S_SYNC, BSL_S_LOAD, BSL_S_RUN
  } bsl_state_t;
endpackage

// >>> hw/bsl_loader.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// echo fifo
module bsl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,       // clock
  input  wire logic             rst,       // sync reset
  input  wire logic             in_valid,  // push request
  output logic                  in_ready,  // not full
  input  wire logic [WIDTH-1:0] in_data,   // push data
  output logic                  out_valid, // not empty
  input  wire logic             out_ready, // pop request
  output logic      [WIDTH-1:0] out_data   // head data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;
  // pointers carry one extra bit so full and empty differ
  wire [AW:0]       used = wr_q - rd_q;

  assign in_ready  = used != (AW+1)'(DEPTH);
  assign out_valid = used != '0;
  assign out_data  = mem_q[rd_q[AW-1:0]];

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (push) mem_q[wr_q[AW-1:0]] <= in_data;
  end
endmodule // bsl_fifo

// ============================================================
// two-flop synchroniser for inputs from outside the clock domain
module bsl_sync2 (
  input  wire logic clk, // clock
  input  wire logic d,   // asynchronous input
  output logic      q    // synchronised copy
);
  logic s1_q;
  always_ff @(posedge clk) begin
    s1_q <= d;
    q    <= s1_q;
  end
endmodule // bsl_sync2

// ============================================================
// bootstrap serial loader
module bsl_loader
  import bsl_pkg::*;
#(
  parameter int RAM_DEPTH  = 512,
  parameter int ECHO_DEPTH = 8
) (
  input  wire logic                         CLK,         // 10 MHz
  input  wire logic                         SYS_RST,     // sync reset
  input  wire logic                         BOOT_MODE,   // strap pin
  input  wire logic                         RXD,         // serial in
  output logic                              TXD,         // serial out
  output logic [15:0]                       RST_VECTOR,  // vector addr
  input  wire logic [15:0]                  CPU_ADDR,    // cpu address
  input  wire logic                         CPU_RD,      // cpu read
  input  wire logic [7:0]                   MAIN_RDATA,  // main rom
  output logic [7:0]                        CPU_RDATA,   // read data
  input  wire logic                         MISC_WR,     // misc write
  input  wire logic [7:0]                   MISC_WDATA,  // write data
  output logic [7:0]                        MISC_RDATA,  // misc value
  input  wire logic [$clog2(RAM_DEPTH)-1:0] RAM_RADDR,   // ram addr
  output logic [7:0]                        RAM_RDATA,   // ram data
  output logic                              LOADING,     // in download
  output logic [$clog2(RAM_DEPTH):0]        LOAD_COUNT,  // bytes kept
  output logic [1:0]                        RATE_SEL,    // chosen rate
  output logic                              OVERRUN,     // byte lost
  output logic                              EXEC_GO,     // jump pulse
  output logic [15:0]                       EXEC_PC      // jump target
);
  import bsl_pkg::*;
  localparam int AW = $clog2(RAM_DEPTH);

  // ==========================================================
  // strap and line synchronisers, strap capture after reset
  logic boot_s2_q, rx_s2_q;
  logic init_q, boot_q;
  // only the second flop of each chain is ever read
  bsl_sync2 u_boot_sync (
    .clk (CLK),
    .d   (BOOT_MODE),
    .q   (boot_s2_q)
  );
  bsl_sync2 u_rx_sync (
    .clk (CLK),
    .d   (RXD),
    .q   (rx_s2_q)
  );

  bsl_state_t state_q;
  bsl_rate_t  rate_q;
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      init_q <= 1'b1;
      boot_q <= 1'b0;
    end else begin
      init_q <= 1'b0;
      if (init_q) boot_q <= boot_s2_q;
    end
  end

  // ==========================================================
  // reset vector and boot rom overlay
  wire rom_en  = MISC_RDATA[BIT_BOOT_EN];
  wire rom_hit = rom_en && (CPU_ADDR[15:8] == BOOT_ROM_PAGE);
  wire [7:0] rom_byte =
    (CPU_ADDR[7:0] == VEC_HI_OFS) ? BOOT_ENTRY[15:8] :
    (CPU_ADDR[7:0] == VEC_LO_OFS) ? BOOT_ENTRY[7:0] : 8'h00;
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      RST_VECTOR <= VEC_MAIN;
      CPU_RDATA  <= 8'h00;
    end else begin
      RST_VECTOR <= boot_q ? VEC_BOOT : VEC_MAIN;
      if (CPU_RD) CPU_RDATA <= rom_hit ? rom_byte : MAIN_RDATA;
    end
  end

  // ==========================================================
  // priority/miscellaneous register: protected bits bootstrap-only
  wire [7:0] misc_prot = boot_q ? MISC_WDATA : MISC_RDATA;
  wire [7:0] misc_d    = (MISC_WDATA & ~MISC_PROT_MASK)
                       | (misc_prot & MISC_PROT_MASK);
  always_ff @(posedge CLK) begin
    if (SYS_RST) MISC_RDATA <= MISC_RST_NORM;
    else if (init_q)
      MISC_RDATA <= boot_s2_q ? MISC_RST_BOOT : MISC_RST_NORM;
    else if (MISC_WR) MISC_RDATA <= misc_d;
  end

  // ==========================================================
  // baud divider: one 16x tick enable
  wire [DIV_W-1:0] div_sel =
    (rate_q == BSL_R_SLOW) ? DIV_SLOW :
    (rate_q == BSL_R_F0)   ? DIV_F0   :
    (rate_q == BSL_R_FD)   ? DIV_FD   : DIV_FAST;
  logic [DIV_W-1:0] div_q;
  // a switch to a shorter divisor can leave the count past the new
  // limit; >= ends that period at once instead of after a wrap
  wire tick = (div_q >= div_sel - 1'b1);
  always_ff @(posedge CLK) begin
    if (SYS_RST || tick) div_q <= '0;
    else div_q <= div_q + 1'b1;
  end

  // ==========================================================
  // receiver, 16x oversampled, middle-of-bit sampling
  logic       rx_busy_q;
  logic [3:0] rx_smp_q, rx_bit_q;
  logic [7:0] rx_sh_q;
  logic       rx_done_q;
  wire rx_mid = rx_busy_q && tick && (rx_smp_q == SMP_MID);
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rx_busy_q <= 1'b0;
      rx_smp_q  <= '0;
      rx_bit_q  <= '0;
      rx_sh_q   <= '0;
      rx_done_q <= 1'b0;
    end else begin
      rx_done_q <= 1'b0;
      if (tick && !rx_busy_q && !rx_s2_q) begin
        rx_busy_q <= 1'b1;
        rx_smp_q  <= '0;
        rx_bit_q  <= '0;
      end else if (tick && rx_busy_q) begin
        rx_smp_q <= rx_smp_q + 1'b1;
      end
      if (rx_mid) begin
        rx_bit_q <= rx_bit_q + 1'b1;
        // false start bit: drop back to hunting
        if (rx_bit_q == '0 && rx_s2_q) rx_busy_q <= 1'b0;
        else if (rx_bit_q == BIT_STOP) begin
          rx_busy_q <= 1'b0;
          rx_done_q <= rx_s2_q;
        end else if (rx_bit_q != '0)
          rx_sh_q <= {rx_s2_q, rx_sh_q[7:1]};
      end
    end
  end

  // ==========================================================
  // idle-line timeout, counted in 16x ticks
  wire [TO_W-1:0] to_sel =
    (rate_q == BSL_R_F0) ? TO_F0 :
    (rate_q == BSL_R_FD) ? TO_FD : TO_STD;
  logic [TO_W-1:0] idle_q;
  always_ff @(posedge CLK) begin
    if (SYS_RST || rx_busy_q || !rx_s2_q) idle_q <= '0;
    else if (tick && idle_q != to_sel) idle_q <= idle_q + 1'b1;
  end
  wire timed_out = (idle_q == to_sel);

  // ==========================================================
  // download: hold register, ram and echo fifo
  logic [7:0]  hold_q;
  logic        hold_v_q;
  logic [AW:0] addr_q;
  logic [7:0]  ram_q [RAM_DEPTH];
  logic        fifo_rdy, fifo_v, buf_v_q;
  logic [7:0]  fifo_data;
  wire ram_full = (addr_q == (AW+1)'(RAM_DEPTH));
  // the held byte counts too, else a byte taken while the last slot
  // is written would land past the end and wrap onto the first one
  wire [AW:0] kept = addr_q + (AW+1)'(hold_v_q);
  wire room = (kept != (AW+1)'(RAM_DEPTH));
  // a byte is only kept once the echo path accepts it, so a
  // stalled transmitter throttles ram writes rather than echoes
  wire store = hold_v_q && fifo_rdy && (state_q == BSL_S_LOAD);
  wire got   = rx_done_q && (state_q == BSL_S_LOAD);
  wire finish = (state_q == BSL_S_LOAD) && !hold_v_q &&
                ((addr_q != '0 && timed_out) || ram_full);

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      hold_v_q <= 1'b0;
      hold_q   <= '0;
      addr_q   <= '0;
      OVERRUN  <= 1'b0;
    end else begin
      if (got && hold_v_q && !store) OVERRUN <= 1'b1;
      if (got && (!hold_v_q || store) && room) begin
        hold_q   <= rx_sh_q;
        hold_v_q <= 1'b1;
      end else if (store) hold_v_q <= 1'b0;
      if (store) addr_q <= addr_q + 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (store) ram_q[addr_q[AW-1:0]] <= hold_q;
    RAM_RDATA <= ram_q[RAM_RADDR];
  end

  bsl_fifo #(
    .WIDTH (8),
    .DEPTH (ECHO_DEPTH)
  ) u_echo (
    .clk       (CLK),
    .rst       (SYS_RST),
    .in_valid  (hold_v_q && (state_q == BSL_S_LOAD)),
    .in_ready  (fifo_rdy),
    .in_data   (hold_q),
    .out_valid (fifo_v),
    .out_ready (!buf_v_q),
    .out_data  (fifo_data)
  );

  // ==========================================================
  // transmitter: data buffer plus shifter
  logic [7:0] buf_q;
  logic [9:0] tx_sh_q;
  logic [3:0] tx_smp_q, tx_bit_q;
  logic       tx_busy_q;
  wire tx_load = buf_v_q && !tx_busy_q;
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      buf_v_q   <= 1'b0;
      buf_q     <= '0;
      tx_busy_q <= 1'b0;
      tx_sh_q   <= '1;
      tx_smp_q  <= '0;
      tx_bit_q  <= '0;
    end else begin
      if (fifo_v && !buf_v_q) begin
        buf_q   <= fifo_data;
        buf_v_q <= 1'b1;
      end else if (tx_load) buf_v_q <= 1'b0;
      if (tx_load) begin
        tx_sh_q   <= {1'b1, buf_q, 1'b0};
        tx_busy_q <= 1'b1;
        tx_smp_q  <= '0;
        tx_bit_q  <= '0;
      end else if (tx_busy_q && tick) begin
        tx_smp_q <= tx_smp_q + 1'b1;
        if (tx_smp_q == '1) begin
          tx_sh_q  <= {1'b1, tx_sh_q[9:1]};
          tx_bit_q <= tx_bit_q + 1'b1;
          if (tx_bit_q == BIT_STOP) tx_busy_q <= 1'b0;
        end
      end
    end
  end
  assign TXD = tx_sh_q[0];

  // ==========================================================
  // loader sequence
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      state_q <= BSL_S_IDLE;
      rate_q  <= BSL_R_FAST;
      EXEC_GO <= 1'b0;
    end else begin
      EXEC_GO <= 1'b0;
      unique case (state_q)
        BSL_S_IDLE: begin
          if (!init_q && boot_q) state_q <= BSL_S_SYNC;
        end
        BSL_S_SYNC: begin
          if (rx_done_q) begin
            state_q <= BSL_S_LOAD;
            // a slow $FF seen at the fast rate reads as other data
            if (rx_sh_q == SYNC_FF) rate_q <= BSL_R_FAST;
            else if (rx_sh_q == SYNC_F0) rate_q <= BSL_R_F0;
            else if (rx_sh_q == SYNC_FD) rate_q <= BSL_R_FD;
            else rate_q <= BSL_R_SLOW;
          end
        end
        BSL_S_LOAD: begin
          if (finish) begin
            state_q <= BSL_S_RUN;
            EXEC_GO <= 1'b1;
          end
        end
        BSL_S_RUN: state_q <= BSL_S_RUN;
      endcase
    end
  end

  assign EXEC_PC    = LOAD_BASE;
  assign LOADING    = (state_q == BSL_S_LOAD);
  assign LOAD_COUNT = addr_q;
  assign RATE_SEL   = rate_q;
endmodule // bsl_loader
`default_nettype wire

// >>> tb/bsl_loader_chk.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// port checker for the loader
module bsl_loader_chk
  import bsl_pkg::*;
#(
  parameter int RAM_DEPTH = 512
) (
  input wire logic                       CLK,        // clock
  input wire logic                       SYS_RST,    // sync reset
  input wire logic                       BOOT_MODE,  // strap
  input wire logic                       RXD,        // serial in
  input wire logic [15:0]                RST_VECTOR, // vector
  input wire logic [15:0]                CPU_ADDR,   // address
  input wire logic                       CPU_RD,     // read strobe
  input wire logic [7:0]                 MAIN_RDATA, // main rom
  input wire logic [7:0]                 CPU_RDATA,  // read data
  input wire logic                       MISC_WR,    // misc write
  input wire logic [7:0]                 MISC_WDATA, // write data
  input wire logic [7:0]                 MISC_RDATA, // misc value
  input wire logic                       LOADING,    // download
  input wire logic [$clog2(RAM_DEPTH):0] LOAD_COUNT, // bytes kept
  input wire logic [1:0]                 RATE_SEL,   // rate
  input wire logic                       EXEC_GO,    // jump pulse
  input wire logic [15:0]                EXEC_PC     // jump target
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  // small slack for tick phase against the free running divider
  localparam int TO_MIN = int'(TO_STD) * int'(DIV_FAST) - 160;
  logic [16:0] quiet_q;
  always_ff @(posedge CLK) begin
    if (SYS_RST || !RXD) begin
      quiet_q <= '0;
    end else if (quiet_q != '1) begin
      quiet_q <= quiet_q + 1'b1;
    end
  end
  property p_vec_boot;
    $fell(SYS_RST) && BOOT_MODE && $past(BOOT_MODE, 3) |-> ##3
      RST_VECTOR == VEC_BOOT && MISC_RDATA == MISC_RST_BOOT;
  endproperty
  a_vec_boot: assert property (p_vec_boot)
    else $error("boot reset values wrong");
  property p_vec_norm;
    $fell(SYS_RST) && !BOOT_MODE && !$past(BOOT_MODE, 3) |-> ##3
      RST_VECTOR == VEC_MAIN && MISC_RDATA == MISC_RST_NORM;
  endproperty
  a_vec_norm: assert property (p_vec_norm)
    else $error("normal reset values wrong");
  property p_prot;
    MISC_WR && RST_VECTOR == VEC_MAIN |=> MISC_RDATA ==
      (($past(MISC_RDATA) & MISC_PROT_MASK) |
       ($past(MISC_WDATA) & ~MISC_PROT_MASK));
  endproperty
  a_prot: assert property (p_prot)
    else $error("protected bits changed");
  property p_boot_wr;
    MISC_WR && RST_VECTOR == VEC_BOOT |=> MISC_RDATA == $past(MISC_WDATA);
  endproperty
  a_boot_wr: assert property (p_boot_wr)
    else $error("bootstrap write lost");
  property p_rom_hi;
    CPU_RD && CPU_ADDR == VEC_BOOT && MISC_RDATA[BIT_BOOT_EN]
      |=> CPU_RDATA == BOOT_ENTRY[15:8];
  endproperty
  a_rom_hi: assert property (p_rom_hi)
    else $error("boot rom not read");
  property p_unmap;
    CPU_RD && !MISC_RDATA[BIT_BOOT_EN] |=> CPU_RDATA == $past(MAIN_RDATA);
  endproperty
  a_unmap: assert property (p_unmap)
    else $error("main rom not read");
  property p_jump;
    EXEC_GO |-> EXEC_PC == LOAD_BASE && $past(LOADING) ##1 !EXEC_GO;
  endproperty
  a_jump: assert property (p_jump)
    else $error("bad jump pulse");
  property p_silence;
    EXEC_GO && RATE_SEL == 2'h0 && LOAD_COUNT < RAM_DEPTH
      |-> quiet_q >= TO_MIN;
  endproperty
  a_silence: assert property (p_silence)
    else $error("download ended early");
  property p_rate;
    LOADING && $past(LOADING) |-> $stable(RATE_SEL);
  endproperty
  a_rate: assert property (p_rate)
    else $error("rate moved in download");
  property p_count;
    LOADING && $past(LOADING) |-> LOAD_COUNT == $past(LOAD_COUNT) ||
      LOAD_COUNT == $past(LOAD_COUNT) + 1'b1;
  endproperty
  a_count: assert property (p_count)
    else $error("count skipped");
endmodule // bsl_loader_chk

bind bsl_loader bsl_loader_chk #(.RAM_DEPTH(RAM_DEPTH)) chk_u (
  .CLK(CLK), .SYS_RST(SYS_RST), .BOOT_MODE(BOOT_MODE), .RXD(RXD),
  .RST_VECTOR(RST_VECTOR), .CPU_ADDR(CPU_ADDR), .CPU_RD(CPU_RD),
  .MAIN_RDATA(MAIN_RDATA), .CPU_RDATA(CPU_RDATA), .MISC_WR(MISC_WR),
  .MISC_WDATA(MISC_WDATA), .MISC_RDATA(MISC_RDATA), .LOADING(LOADING),
  .LOAD_COUNT(LOAD_COUNT), .RATE_SEL(RATE_SEL), .EXEC_GO(EXEC_GO),
  .EXEC_PC(EXEC_PC)
);
`default_nettype wire

// >>> tb/bsl_host.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// host sending the download and listening to echoes
module bsl_host
  import bsl_pkg::*;
(
  input  wire logic       clk,      // bench clock
  output logic            rxd,      // line into the loader
  input  wire logic       txd,      // echo line
  output logic            got,      // pulse per echoed byte
  output logic [7:0]      got_byte  // echoed byte
);
  localparam int BIT = 16 * int'(DIV_FAST);
  initial rxd = 1'b1;
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    @(negedge clk);
    for (int i = 0; i < 10; i++) begin
      rxd = f[i];
      repeat (BIT) @(negedge clk);
    end
  endtask
  initial begin
    got = 1'b0;
    got_byte = 8'h00;
    forever begin
      @(negedge txd);
      repeat (BIT / 2) @(negedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(negedge clk);
        got_byte[i] = txd;
      end
      repeat (BIT) @(negedge clk);
      // a low stop bit never reports a byte
      got = txd;
      @(negedge clk);
      got = 1'b0;
    end
  end
endmodule // bsl_host
`default_nettype wire

// >>> tb/bsl_loader_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin \
  n_compared++; \
  if ((a) !== (b)) begin \
    n_errors++; \
    $display("[ERR] %0t got %h want %h", $time, a, b); \
  end \
end
// ============================================================
// bench for the bootstrap loader
module bsl_loader_tb_top;
  import bsl_pkg::*;
  localparam int RD = 16;
  localparam int BIT = 16 * int'(DIV_FAST);
  localparam int TO_CYC = int'(TO_STD) * int'(DIV_FAST);
  logic        CLK, SYS_RST, BOOT_MODE, RXD, TXD, CPU_RD, MISC_WR;
  logic        LOADING, OVERRUN, EXEC_GO, got;
  logic [15:0] RST_VECTOR, CPU_ADDR, EXEC_PC;
  logic [7:0]  MAIN_RDATA, CPU_RDATA, MISC_WDATA, MISC_RDATA, RAM_RDATA;
  logic [7:0]  got_byte, m, e;
  logic [3:0]  RAM_RADDR;
  logic [4:0]  LOAD_COUNT;
  logic [1:0]  RATE_SEL;
  logic [31:0] seed = 32'h91CE;
  logic [7:0]  dat [2];
  logic [7:0]  exp_q [$];
  logic [7:0]  syncs [2] = '{SYNC_F0, SYNC_FD};
  logic [1:0]  rates [2] = '{2'(BSL_R_F0), 2'(BSL_R_FD)};
  int          n_errors = 0;
  int          n_compared = 0;
  int          w;
  bsl_loader #(.RAM_DEPTH(RD), .ECHO_DEPTH(8)) dut_u (
    .CLK(CLK), .SYS_RST(SYS_RST), .BOOT_MODE(BOOT_MODE), .RXD(RXD),
    .TXD(TXD), .RST_VECTOR(RST_VECTOR), .CPU_ADDR(CPU_ADDR),
    .CPU_RD(CPU_RD), .MAIN_RDATA(MAIN_RDATA), .CPU_RDATA(CPU_RDATA),
    .MISC_WR(MISC_WR), .MISC_WDATA(MISC_WDATA), .MISC_RDATA(MISC_RDATA),
    .RAM_RADDR(RAM_RADDR), .RAM_RDATA(RAM_RDATA), .LOADING(LOADING),
    .LOAD_COUNT(LOAD_COUNT), .RATE_SEL(RATE_SEL), .OVERRUN(OVERRUN),
    .EXEC_GO(EXEC_GO), .EXEC_PC(EXEC_PC)
  );
  bsl_host host_u (
    .clk(CLK), .rxd(RXD), .txd(TXD), .got(got), .got_byte(got_byte)
  );
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic summarize();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic pulse_rst();
    SYS_RST = 1'b1;
    repeat (2) @(negedge CLK);
    SYS_RST = 1'b0;
    repeat (4) @(negedge CLK);
  endtask
  // main rom data is random so a stale read cannot match
  task automatic rd(input logic [15:0] a);
    seed = lfsr(seed);
    m = seed[7:0];
    CPU_ADDR = a;
    MAIN_RDATA = m;
    CPU_RD = 1'b1;
    @(negedge CLK);
    CPU_RD = 1'b0;
    @(negedge CLK);
  endtask
  task automatic wr(input logic [7:0] d);
    MISC_WDATA = d;
    MISC_WR = 1'b1;
    @(negedge CLK);
    MISC_WR = 1'b0;
    @(negedge CLK);
  endtask
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  always @(posedge got) begin
    if (exp_q.size() == 0) begin
      n_errors++;
      $display("[ERR] %0t echo without a sent byte", $time);
    end else begin
      e = exp_q.pop_front();
      `CHK(got_byte, e)
    end
  end
  initial begin
    repeat (140000) @(posedge CLK);
    n_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    summarize();
  end
  initial begin
    {BOOT_MODE, CPU_RD, MISC_WR} = 3'b100;
    {CPU_ADDR, MAIN_RDATA, MISC_WDATA, RAM_RADDR} = '0;
    pulse_rst();
    `CHK(RST_VECTOR, VEC_BOOT)
    `CHK(MISC_RDATA, MISC_RST_BOOT)
    rd(VEC_BOOT);
    `CHK(CPU_RDATA, BOOT_ENTRY[15:8])
    rd(VEC_BOOT + 16'h1);
    `CHK(CPU_RDATA, BOOT_ENTRY[7:0])
    host_u.send(SYNC_FF);
    `CHK(LOADING, 1'b1)
    `CHK(RATE_SEL, 2'(BSL_R_FAST))
    for (int i = 0; i < 2; i++) begin
      seed = lfsr(seed);
      dat[i] = seed[7:0];
      exp_q.push_back(dat[i]);
      host_u.send(dat[i]);
    end
    w = 0;
    while (EXEC_GO !== 1'b1 && w < 60000) begin
      @(negedge CLK);
      w++;
    end
    `CHK(w > TO_CYC - BIT && w < TO_CYC + BIT, 1'b1)
    `CHK(EXEC_PC, LOAD_BASE)
    `CHK(LOAD_COUNT, 5'd2)
    `CHK(OVERRUN, 1'b0)
    `CHK(exp_q.size(), 0)
    for (int i = 0; i < 2; i++) begin
      RAM_RADDR = 4'(i);
      repeat (2) @(negedge CLK);
      `CHK(RAM_RDATA, dat[i])
    end
    wr(8'h25);
    `CHK(MISC_RDATA, 8'h25)
    rd(VEC_BOOT);
    `CHK(CPU_RDATA, m)
    BOOT_MODE = 1'b0;
    repeat (3) @(negedge CLK);
    pulse_rst();
    `CHK(RST_VECTOR, VEC_MAIN)
    `CHK(MISC_RDATA, MISC_RST_NORM)
    wr(8'hFF);
    `CHK(MISC_RDATA, ~MISC_PROT_MASK)
    rd(VEC_BOOT);
    `CHK(CPU_RDATA, m)
    BOOT_MODE = 1'b1;
    for (int i = 0; i < 2; i++) begin
      repeat (3) @(negedge CLK);
      pulse_rst();
      host_u.send(syncs[i]);
      `CHK(RATE_SEL, rates[i])
    end
    summarize();
  end
endmodule // bsl_loader_tb_top
`default_nettype wire
